// ==== hw/tla_pkg.sv ====
package tla_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CONV_TIME_US = 31250;
    localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
    localparam int CYC_W = 22;

    localparam logic [3:0] R_LTEMP = 4'h0;
    localparam logic [3:0] R_RTEMP_HI = 4'h1;
    localparam logic [3:0] R_RTEMP_LO = 4'h2;
    localparam logic [3:0] R_CFG = 4'h3;
    localparam logic [3:0] R_RATE = 4'h4;
    localparam logic [3:0] R_LHIGH = 4'h5;
    localparam logic [3:0] R_RHIGH_HI = 4'h6;
    localparam logic [3:0] R_RHIGH_LO = 4'h7;
    localparam logic [3:0] R_RLOW_HI = 4'h8;
    localparam logic [3:0] R_RLOW_LO = 4'h9;
    localparam logic [3:0] R_RCRIT = 4'ha;
    localparam logic [3:0] R_HYST = 4'hb;
    localparam logic [3:0] R_OFS_HI = 4'hc;
    localparam logic [3:0] R_OFS_LO = 4'hd;
    localparam logic [3:0] R_STAT = 4'he;
    localparam logic [3:0] R_MODE = 4'hf;

    localparam int CFG_MASK = 7;
    localparam int CFG_STBY = 6;
    localparam int CFG_PWMD = 5;
    localparam int MOD_COMP = 0;
    localparam int MOD_ACFG = 1;

    localparam int ST_BUSY = 7;
    localparam int ST_LHI = 6;
    localparam int ST_RHI = 4;
    localparam int ST_RLO = 3;
    localparam int ST_OPEN = 2;
    localparam int ST_RCRIT = 1;
    localparam logic [7:0] ST_IGNORE = 8'h84;

    localparam int V_LHI = 0;
    localparam int V_RHI = 1;
    localparam int V_RLO = 2;
    localparam int V_RCRIT = 3;

    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] LHIGH_RST = 8'h46;
    localparam logic [7:0] RHIGH_RST = 8'h46;
    localparam logic [7:0] RLOW_RST = 8'h00;
    localparam logic [7:0] RCRIT_RST = 8'h6e;
    localparam logic [7:0] HYST_RST = 8'h0a;

    typedef enum logic [1:0] {
        TLA_CONV = 2'b00,
        TLA_WAIT = 2'b01,
        TLA_STBY = 2'b11
    } tla_state_t;
endpackage

// ==== hw/tla_cmp_if.sv ====
`timescale 1ns/10ps
interface tla_cmp_if;
    logic signed [15:0] local_w;
    logic signed [15:0] remote_w;
    logic signed [15:0] lhigh;
    logic signed [15:0] rhigh;
    logic signed [15:0] rlow;
    logic signed [15:0] rcrit;
    logic [7:0] hyst;
    logic [3:0] prev;
    logic [3:0] viol;
    modport ctl(output local_w, remote_w, lhigh, rhigh, rlow, rcrit, hyst, prev,
        input viol);
    modport cmp(input local_w, remote_w, lhigh, rhigh, rlow, rcrit, hyst, prev,
        output viol);
endinterface

// ==== hw/tla_cmp.sv ====
`timescale 1ns/10ps
module tla_cmp
    import tla_pkg::*;
(
    tla_cmp_if.cmp c
);
    // A flag already set holds until the reading backs off by the hysteresis,
    // which stops the alert from chattering around a limit.
    function automatic logic hit(
        input logic signed [15:0] v,
        input logic signed [15:0] lim,
        input logic [7:0] h,
        input logic prev,
        input logic up
    );
        logic signed [16:0] hy;
        logic signed [16:0] thr;
        hy = $signed({1'b0, h, 8'h00});
        if (up) begin
            thr = prev ? 17'(lim) - hy : 17'(lim);
            hit = 17'(v) > thr;
        end else begin
            thr = prev ? 17'(lim) + hy : 17'(lim);
            hit = 17'(v) < thr;
        end
    endfunction

    always_comb begin
        c.viol[V_LHI] = hit(c.local_w, c.lhigh, c.hyst, c.prev[V_LHI], 1'b1);
        c.viol[V_RHI] = hit(c.remote_w, c.rhigh, c.hyst, c.prev[V_RHI], 1'b1);
        c.viol[V_RLO] = hit(c.remote_w, c.rlow, c.hyst, c.prev[V_RLO], 1'b0);
        c.viol[V_RCRIT] = hit(c.remote_w, c.rcrit, c.hyst, c.prev[V_RCRIT], 1'b1);
    end
endmodule

// ==== hw/tla_top.sv ====
`timescale 1ns/10ps
module tla_top
    import tla_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [7:0] local_raw,
    input wire logic [10:0] remote_raw,
    input wire logic diode_open,
    input wire logic pwm_req,
    output logic alert_o,
    output logic alert_oe,
    output logic tcrit_o,
    output logic tcrit_oe,
    output logic pwm_o,
    output logic pwm_oe
);
    typedef struct packed {
        tla_state_t state;
        logic [CYC_W-1:0] cyc;
        logic [7:0] unit;
        logic [7:0] ltemp;
        logic [15:0] rtemp;
        logic [7:0] cfg;
        logic [7:0] mode;
        logic [7:0] rate;
        logic [7:0] lhigh;
        logic [7:0] rhh;
        logic [7:0] rhl;
        logic [7:0] rlh;
        logic [7:0] rll;
        logic [7:0] rcrit;
        logic [7:0] hyst;
        logic [7:0] ofh;
        logic [7:0] ofl;
        logic [7:0] status;
        logic [3:0] cond;
        logic alert;
        logic tcrit;
        logic pwm;
        logic [7:0] rdata;
    } tla_st_t;

    localparam tla_st_t ST_RST = '{
        state: TLA_CONV,
        cyc: '0,
        unit: 8'h00,
        ltemp: 8'h00,
        rtemp: 16'h0000,
        cfg: CFG_RST,
        mode: MODE_RST,
        rate: RATE_RST,
        lhigh: LHIGH_RST,
        rhh: RHIGH_RST,
        rhl: 8'h00,
        rlh: RLOW_RST,
        rll: 8'h00,
        rcrit: RCRIT_RST,
        hyst: HYST_RST,
        ofh: 8'h00,
        ofl: 8'h00,
        status: 8'h00,
        cond: 4'h0,
        alert: 1'b0,
        tcrit: 1'b0,
        pwm: 1'b0,
        rdata: 8'h00
    };

    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CONV_CYCLES - 1);

    tla_st_t q;
    tla_st_t n;
    logic conv_end;
    logic busy;
    logic comp_mode;
    logic stat_rd;
    logic [15:0] rcorr;
    logic [7:0] flags;

    tla_cmp_if cif();

    tla_cmp u_cmp (
        .c(cif)
    );

    // The offset is added without saturation; a large offset near the range
    // ends wraps, so software must keep it to a few degrees.
    assign rcorr = ({remote_raw, 5'h00} + {q.ofh, q.ofl}) & 16'hffe0;

    assign cif.local_w = {local_raw, 8'h00};
    assign cif.remote_w = rcorr;
    assign cif.lhigh = {q.lhigh, 8'h00};
    assign cif.rhigh = {q.rhh, q.rhl};
    assign cif.rlow = {q.rlh, q.rll};
    assign cif.rcrit = {q.rcrit, 8'h00};
    assign cif.hyst = q.hyst;
    assign cif.prev = q.cond;

    assign busy = (q.state == TLA_CONV);
    assign comp_mode = q.mode[MOD_COMP];
    assign stat_rd = rd_en && (addr == R_STAT);

    function automatic logic [7:0] rd_mux(
        input tla_st_t s,
        input logic [3:0] a,
        input logic bsy
    );
        logic [7:0] r;
        r = 8'h00;
        if (a == R_LTEMP) begin
            r = s.ltemp;
        end else if (a == R_RTEMP_HI) begin
            r = s.rtemp[15:8];
        end else if (a == R_RTEMP_LO) begin
            r = s.rtemp[7:0];
        end else if (a == R_CFG) begin
            r = s.cfg;
        end else if (a == R_RATE) begin
            r = s.rate;
        end else if (a == R_LHIGH) begin
            r = s.lhigh;
        end else if (a == R_RHIGH_HI) begin
            r = s.rhh;
        end else if (a == R_RHIGH_LO) begin
            r = s.rhl;
        end else if (a == R_RLOW_HI) begin
            r = s.rlh;
        end else if (a == R_RLOW_LO) begin
            r = s.rll;
        end else if (a == R_RCRIT) begin
            r = s.rcrit;
        end else if (a == R_HYST) begin
            r = s.hyst;
        end else if (a == R_OFS_HI) begin
            r = s.ofh;
        end else if (a == R_OFS_LO) begin
            r = s.ofl;
        end else if (a == R_STAT) begin
            r = s.status;
            r[ST_BUSY] = bsy;
        end else begin
            r = s.mode;
        end
        rd_mux = r;
    endfunction

    always_comb begin
        n = q;
        conv_end = 1'b0;
        flags = 8'h00;
        n.rdata = rd_en ? rd_mux(q, addr, busy) : 8'h00;

        case (q.state)
            TLA_CONV: begin
                if (q.cyc == CYC_LAST) begin
                    conv_end = 1'b1;
                    n.cyc = '0;
                    n.unit = 8'h00;
                    if (q.cfg[CFG_STBY]) begin
                        n.state = TLA_STBY;
                    end else if (q.rate != 8'h00) begin
                        n.state = TLA_WAIT;
                    end else begin
                        n.state = TLA_CONV;
                    end
                end else begin
                    n.cyc = q.cyc + 1'b1;
                end
            end
            TLA_WAIT: begin
                if (q.cfg[CFG_STBY]) begin
                    n.state = TLA_STBY;
                    n.cyc = '0;
                end else if (q.cyc == CYC_LAST) begin
                    n.cyc = '0;
                    if (q.unit + 8'h01 >= q.rate) begin
                        n.state = TLA_CONV;
                        n.unit = 8'h00;
                    end else begin
                        n.unit = q.unit + 8'h01;
                    end
                end else begin
                    n.cyc = q.cyc + 1'b1;
                end
            end
            TLA_STBY: begin
                n.cyc = '0;
                if (!q.cfg[CFG_STBY]) begin
                    n.state = TLA_CONV;
                end
            end
            default: begin
                n.state = TLA_CONV;
                n.cyc = '0;
            end
        endcase

        if (wr_en) begin
            if (addr == R_CFG) begin
                n.cfg = wdata;
            end else if (addr == R_RATE) begin
                n.rate = wdata;
            end else if (addr == R_LHIGH) begin
                n.lhigh = wdata;
            end else if (addr == R_RHIGH_HI) begin
                n.rhh = wdata;
            end else if (addr == R_RHIGH_LO) begin
                n.rhl = wdata & 8'he0;
            end else if (addr == R_RLOW_HI) begin
                n.rlh = wdata;
            end else if (addr == R_RLOW_LO) begin
                n.rll = wdata & 8'he0;
            end else if (addr == R_RCRIT) begin
                n.rcrit = wdata;
            end else if (addr == R_HYST) begin
                n.hyst = wdata;
            end else if (addr == R_OFS_HI) begin
                n.ofh = wdata;
            end else if (addr == R_OFS_LO) begin
                n.ofl = wdata & 8'he0;
            end else if (addr == R_MODE) begin
                n.mode = wdata & 8'h03;
            end
        end

        // Reading the status empties it; an alert pending at that moment in
        // interrupt mode masks the pin until software clears the mask.
        if (stat_rd) begin
            n.status = 8'h00;
            if (!comp_mode && |(q.status & ~ST_IGNORE)) begin
                n.cfg[CFG_MASK] = 1'b1;
            end
        end

        // Flags set at the end of a conversion win over a same-cycle clear,
        // so a new violation is never lost to a racing status read.
        if (conv_end) begin
            n.ltemp = local_raw;
            n.rtemp = rcorr;
            n.cond = cif.viol;
            flags[ST_LHI] = cif.viol[V_LHI];
            flags[ST_RHI] = cif.viol[V_RHI];
            flags[ST_RLO] = cif.viol[V_RLO];
            flags[ST_RCRIT] = cif.viol[V_RCRIT];
            flags[ST_OPEN] = diode_open;
            n.status = n.status | flags;
            n.tcrit = cif.viol[V_RCRIT];
        end

        if (n.cfg[CFG_MASK]) begin
            n.alert = 1'b0;
        end else if (n.mode[MOD_COMP]) begin
            n.alert = |n.cond;
        end else begin
            n.alert = |(n.status & ~ST_IGNORE);
        end

        n.pwm = pwm_req && !(n.state == TLA_STBY && n.cfg[CFG_PWMD]);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= ST_RST;
        end else if (ce) begin
            q <= n;
        end
    end

    // Open-drain pins only ever pull low; the enables carry the state.
    assign alert_o = 1'b0;
    assign alert_oe = q.alert;
    assign tcrit_o = 1'b0;
    assign tcrit_oe = q.tcrit;
    assign pwm_o = 1'b0;
    assign pwm_oe = q.pwm;
    assign rdata = q.rdata;

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    tcrit_follow_a: assert property (
        ce && conv_end |=> tcrit_oe == $past(cif.viol[V_RCRIT]))
        else $error("critical pin does not follow the critical comparison");

    mask_gate_a: assert property (q.cfg[CFG_MASK] |-> !alert_oe)
        else $error("alert driven while masked");

    set_on_end_a: assert property (
        ce && conv_end && cif.viol[V_RLO] |=> q.status[ST_RLO])
        else $error("low-limit flag not set at conversion end");

    stat_clear_a: assert property (
        ce && stat_rd && !conv_end |=> q.status == 8'h00)
        else $error("status not cleared by its read");

    auto_mask_a: assert property (
        ce && stat_rd && !comp_mode && |(q.status & ~ST_IGNORE) |=> q.cfg[CFG_MASK])
        else $error("status read did not set the mask bit");

    int_release_a: assert property (
        ce && stat_rd && !comp_mode && !wr_en && !conv_end |=> !alert_oe)
        else $error("alert held after interrupt-mode status read");

    comp_release_a: assert property (
        ce && conv_end && comp_mode && cif.viol == 4'h0 && !wr_en |=> !alert_oe)
        else $error("comparator mode did not release alert");

    int_assert_a: assert property (
        ce && !stat_rd && !wr_en && !comp_mode && !q.cfg[CFG_MASK]
        && |(q.status & ~ST_IGNORE) |=> alert_oe)
        else $error("pending status did not drive alert");

    conv_len_a: assert property (
        q.state == TLA_CONV |-> q.cyc <= CYC_LAST)
        else $error("conversion longer than its fixed length");

    rate_idle_a: assert property (
        ce && conv_end && q.rate != 8'h00 && !q.cfg[CFG_STBY] |=> q.state == TLA_WAIT)
        else $error("no idle inserted for nonzero rate");

    stby_hold_a: assert property (
        ce && q.state == TLA_STBY && q.cfg[CFG_STBY] && !wr_en |=> q.state == TLA_STBY)
        else $error("conversion resumed in standby");

    pwm_stby_a: assert property (
        q.state == TLA_STBY && q.cfg[CFG_PWMD] |-> !pwm_oe)
        else $error("fan output driven in disabled standby");

    alert_cycle_c: cover property (alert_oe ##1 stat_rd ##1 !alert_oe);
    comp_cycle_c: cover property (comp_mode && alert_oe ##[1:40] !alert_oe);
    stby_cycle_c: cover property (q.state == TLA_STBY ##[1:40] q.state == TLA_CONV);
    tcrit_cycle_c: cover property (tcrit_oe ##[1:40] !tcrit_oe);
endmodule

// ==== tb/tla_host.sv ====
`timescale 1ns/10ps
// Host that owns the register strobes and services the alert line.
module tla_host
    import tla_pkg::*;
(
    input wire logic ref_clk,
    input wire logic alert_o,
    input wire logic alert_oe,
    input wire logic [7:0] rdata,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en,
    output logic alert_n
);
    // The pin has a pull-up, so a released pin reads high.
    assign alert_n = alert_oe ? alert_o : 1'b1;
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // Released lines show the inverse so a stale value never passes.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
    // Read the cause first, then re-enable alerts.
    task automatic service(output logic [7:0] st);
        rd(R_STAT, st);
        wr(R_CFG, 8'h00);
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import tla_pkg::*;
    localparam int NC = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] local_raw = 8'h19;
    logic [10:0] remote_raw = 11'h000;
    logic diode_open = 1'b0;
    logic pwm_req = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v;
    logic wr_en, rd_en, alert_o, alert_oe, tcrit_o, tcrit_oe, pwm_o, pwm_oe, alert_n;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int p;
    logic [3:0] ra [12] = '{R_CFG, R_RATE, R_LHIGH, R_RHIGH_HI, R_RHIGH_LO, R_RLOW_HI,
        R_RLOW_LO, R_RCRIT, R_HYST, R_OFS_HI, R_OFS_LO, R_MODE};
    logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h46, 8'h46, 8'h00, 8'h00, 8'h00, 8'h6e,
        8'h0a, 8'h00, 8'h00, 8'h00};

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    tla_top #(.CONV_CYCLES(NC)) uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .local_raw(local_raw),
        .remote_raw(remote_raw), .diode_open(diode_open), .pwm_req(pwm_req),
        .alert_o(alert_o), .alert_oe(alert_oe), .tcrit_o(tcrit_o), .tcrit_oe(tcrit_oe),
        .pwm_o(pwm_o), .pwm_oe(pwm_oe));
    tla_host host (.ref_clk(ref_clk), .alert_o(alert_o), .alert_oe(alert_oe),
        .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .alert_n(alert_n));

    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        check(d & m, e);
    endtask
    task automatic setin(input logic [7:0] l, input logic [10:0] r);
        @(posedge ref_clk);
        local_raw <= l;
        remote_raw <= r;
    endtask
    task automatic wait_alert(input logic lvl);
        int i;
        for (i = 0; i < 200 && alert_n !== lvl; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 200) begin
            fails++;
            test_done();
        end
    endtask
    // One status read between two 45-cycle waits flushes flags left from earlier inputs.
    task automatic settle();
        repeat (45) @(posedge ref_clk);
        host.rd(R_STAT, v);
        repeat (45) @(posedge ref_clk);
    endtask
    // Cycles between two alert falls, with the host servicing in between.
    task automatic period_of(output int pp);
        int t0;
        wait_alert(1'b0);
        t0 = cyc;
        host.service(v);
        wait_alert(1'b0);
        pp = cyc - t0;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) rdc(ra[i], 8'hff, rv[i]);
        host.wr(R_OFS_HI, 8'h01);
        setin(8'h50, 11'h000);
        wait_alert(1'b0);
        host.wr(R_LTEMP, 8'haa);
        rdc(R_LTEMP, 8'hff, 8'h50);
        rdc(R_STAT, 8'h7f, 8'h40);
        check({7'h00, alert_n}, 8'h01);
        rdc(R_CFG, 8'hff, 8'h80);
        repeat (45) @(posedge ref_clk);
        #1;
        check({7'h00, alert_n}, 8'h01);
        rdc(R_STAT, 8'h7f, 8'h40);
        host.service(v);
        period_of(p);
        check(8'(p), 8'(NC));
        host.wr(R_RATE, 8'h01);
        period_of(p);
        period_of(p);
        check(8'(p), 8'(2 * NC));
        host.wr(R_RATE, 8'h00);
        setin(8'h19, 11'h341);
        settle();
        rdc(R_RTEMP_HI, 8'hff, 8'h69);
        rdc(R_RTEMP_LO, 8'hff, 8'h20);
        rdc(R_STAT, 8'h7f, 8'h10);
        setin(8'h19, 11'h3a0);
        settle();
        check({7'h00, tcrit_oe}, 8'h01);
        rdc(R_STAT, 8'h7f, 8'h12);
        setin(8'h19, 11'h348);
        settle();
        check({7'h00, tcrit_oe}, 8'h01);
        setin(8'h19, 11'h300);
        settle();
        check({7'h00, tcrit_oe}, 8'h00);
        setin(8'h19, 11'h7e0);
        settle();
        rdc(R_STAT, 8'h7f, 8'h08);
        host.wr(R_MODE, 8'h01);
        host.wr(R_CFG, 8'h00);
        setin(8'h19, 11'h100);
        settle();
        setin(8'h50, 11'h100);
        wait_alert(1'b0);
        rdc(R_STAT, 8'h7f, 8'h40);
        rdc(R_CFG, 8'hff, 8'h00);
        check({7'h00, alert_n}, 8'h00);
        setin(8'h19, 11'h100);
        wait_alert(1'b1);
        @(posedge ref_clk);
        pwm_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({7'h00, pwm_oe}, 8'h01);
        host.wr(R_CFG, 8'h60);
        repeat (25) @(posedge ref_clk);
        setin(8'h50, 11'h100);
        repeat (45) @(posedge ref_clk);
        #1;
        check({7'h00, pwm_oe}, 8'h00);
        rdc(R_LTEMP, 8'hff, 8'h19);
        host.wr(R_CFG, 8'h40);
        repeat (3) @(posedge ref_clk);
        check({7'h00, pwm_oe}, 8'h01);
        check({6'h00, tcrit_o, pwm_o}, 8'h00);
        host.wr(R_MODE, 8'h00);
        host.wr(R_CFG, 8'h00);
        setin(8'h19, 11'h100);
        diode_open <= 1'b1;
        settle();
        #1;
        check({7'h00, alert_n}, 8'h01);
        rdc(R_STAT, 8'h7f, 8'h04);
        rdc(R_CFG, 8'hff, 8'h00);
        @(posedge ref_clk);
        ce <= 1'b0;
        host.wr(R_HYST, 8'h05);
        @(posedge ref_clk);
        ce <= 1'b1;
        rdc(R_HYST, 8'hff, 8'h0a);
        test_done();
    end
endmodule
